// ==== src/sjtap_pkg.sv ====
package sjtap_pkg;

    // =====================================================================
    // widths
    localparam int IR_W = 3;
    localparam int ID_W = 32;

    // =====================================================================
    // instruction codes
    localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;

    // capture pattern of the instruction register
    localparam logic [1:0] IR_CAP_LO = 2'h1;
    localparam logic IR_CAP_HI = 1'h0;

    // bypass bit capture value
    localparam logic BYP_CAP = 1'h0;

    // =====================================================================
    // tap controller states
    typedef enum logic [3:0] {
        TAP_EXIT2_DR = 4'h0,
        TAP_EXIT1_DR = 4'h1,
        TAP_SHIFT_DR = 4'h2,
        TAP_PAUSE_DR = 4'h3,
        TAP_SEL_IR = 4'h4,
        TAP_UPDATE_DR = 4'h5,
        TAP_CAPTURE_DR = 4'h6,
        TAP_SEL_DR = 4'h7,
        TAP_EXIT2_IR = 4'h8,
        TAP_EXIT1_IR = 4'h9,
        TAP_SHIFT_IR = 4'ha,
        TAP_PAUSE_IR = 4'hb,
        TAP_RTI = 4'hc,
        TAP_UPDATE_IR = 4'hd,
        TAP_CAPTURE_IR = 4'he,
        TAP_TLR = 4'hf
    } sjtap_state_e;

endpackage : sjtap_pkg

// ==== src/sjtap_sync.sv ====
`timescale 1ns/1ps

// =====================================================================
// two-stage level synchroniser
module sjtap_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic d,
    output logic q
);

    logic meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'h0;
            q <= 1'h0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : sjtap_sync

// ==== src/sjtap_sreg.sv ====
`timescale 1ns/1ps

// =====================================================================
// capture/shift register, shifts toward bit 0
module sjtap_sreg #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] cap_val,
    input wire logic cap,
    input wire logic shift,
    input wire logic sin,
    output logic [W-1:0] q,
    output logic sout
);

    logic [W-1:0] next_q;

    generate
        if (W == 1) begin : g_one
            assign next_q = sin;
        end else begin : g_many
            assign next_q = {sin, q[W-1:1]};
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (cap) begin
            q <= cap_val;
        end else if (shift) begin
            q <= next_q;
        end
    end

    assign sout = q[0];

endmodule : sjtap_sreg

// ==== src/sjtap_port.sv ====
`timescale 1ns/1ps

module sjtap_port
    import sjtap_pkg::*;
#(
    parameter int BSR_W = 8,
    parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001 // arbitrary value
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tck,
    input wire logic tms_pin,
    input wire logic tms_float,
    input wire logic tdi_pin,
    input wire logic tdi_float,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [BSR_W-1:0] bsr_pins_in,
    output logic [BSR_W-1:0] bsr_drive,
    output logic ram_out_extest,
    output logic ram_out_hiz
);

    // =====================================================================
    // tck domain reset
    // power-up reset asserts at once; release is retimed to tck, so the
    // controller stays in reset until tck actually runs
    logic trst_n;

    sjtap_sync u_trst_sync (
        .clk(tck),
        .rstn(rstn),
        .d(1'h1),
        .q(trst_n)
    );

    // =====================================================================
    // pin conditioning
    logic tms_eff;
    logic tdi_eff;

    assign tms_eff = tms_pin | tms_float;
    assign tdi_eff = tdi_pin | tdi_float;

    // =====================================================================
    // controller
    sjtap_state_e state;
    sjtap_state_e next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            TAP_TLR: next_state = tms_eff ? TAP_TLR : TAP_RTI;
            TAP_RTI: next_state = tms_eff ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: next_state = tms_eff ? TAP_SEL_IR : TAP_CAPTURE_DR;
            TAP_CAPTURE_DR: next_state = tms_eff ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_state = tms_eff ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_state = tms_eff ? TAP_UPDATE_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_state = tms_eff ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_state = tms_eff ? TAP_UPDATE_DR : TAP_SHIFT_DR;
            TAP_UPDATE_DR: next_state = tms_eff ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: next_state = tms_eff ? TAP_TLR : TAP_CAPTURE_IR;
            TAP_CAPTURE_IR: next_state = tms_eff ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_state = tms_eff ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_state = tms_eff ? TAP_UPDATE_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_state = tms_eff ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_state = tms_eff ? TAP_UPDATE_IR : TAP_SHIFT_IR;
            TAP_UPDATE_IR: next_state = tms_eff ? TAP_SEL_DR : TAP_RTI;
        endcase
    end

    // no state changes without tck edges, so floating pins leave it alone
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            state <= TAP_TLR;
        end else begin
            state <= next_state;
        end
    end

    logic in_dr_side;

    assign in_dr_side = (state == TAP_RTI) || (state == TAP_SEL_DR) ||
                        (state == TAP_CAPTURE_DR) || (state == TAP_SHIFT_DR) ||
                        (state == TAP_EXIT1_DR) || (state == TAP_PAUSE_DR) ||
                        (state == TAP_EXIT2_DR) || (state == TAP_UPDATE_DR);

    // =====================================================================
    // instruction register
    logic [IR_W-1:0] ir_active;
    logic [IR_W-1:0] ir_q;
    logic ir_sout;
    logic ir_cap;
    logic ir_shift;

    assign ir_cap = (state == TAP_CAPTURE_IR);
    assign ir_shift = (state == TAP_SHIFT_IR);

    sjtap_sreg #(.W(IR_W)) u_ir (
        .clk(tck),
        .rstn(trst_n),
        .cap_val({IR_CAP_HI, IR_CAP_LO}),
        .cap(ir_cap),
        .shift(ir_shift),
        .sin(tdi_eff),
        .q(ir_q),
        .sout(ir_sout)
    );

    // held instruction moves on the falling edge so it is stable for a
    // whole tck period before the next capture or shift
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_active <= IR_IDCODE;
        end else if (state == TAP_TLR) begin
            ir_active <= IR_IDCODE;
        end else if (state == TAP_UPDATE_IR) begin
            ir_active <= ir_q;
        end
    end

    // =====================================================================
    // data register selection
    logic sel_id;
    logic sel_bsr;
    logic sel_byp;

    always_comb begin
        sel_id = 1'h0;
        sel_bsr = 1'h0;
        sel_byp = 1'h0;
        unique case (ir_active)
            IR_IDCODE: sel_id = 1'h1;
            IR_EXTEST, IR_SAMPLE, IR_SAMPLEZ: sel_bsr = 1'h1;
            default: sel_byp = 1'h1; // unused codes act as bypass
        endcase
    end

    logic dr_cap;
    logic dr_shift;

    assign dr_cap = (state == TAP_CAPTURE_DR);
    assign dr_shift = (state == TAP_SHIFT_DR);

    // =====================================================================
    // identification register
    logic [ID_W-1:0] id_q;
    logic id_sout;

    sjtap_sreg #(.W(ID_W)) u_id (
        .clk(tck),
        .rstn(trst_n),
        .cap_val(ID_CODE),
        .cap(dr_cap && sel_id),
        .shift(dr_shift && sel_id),
        .sin(tdi_eff),
        .q(id_q),
        .sout(id_sout)
    );

    // =====================================================================
    // bypass bit
    logic byp_q;
    logic byp_sout;

    sjtap_sreg #(.W(1)) u_byp (
        .clk(tck),
        .rstn(trst_n),
        .cap_val(BYP_CAP),
        .cap(dr_cap && sel_byp),
        .shift(dr_shift && sel_byp),
        .sin(tdi_eff),
        .q(byp_q),
        .sout(byp_sout)
    );

    // =====================================================================
    // boundary register
    // ram pins are unrelated to tck; retimed first, so a capture is only
    // meaningful when the pins were held steady for a few tck periods
    logic [BSR_W-1:0] pins_sync;
    logic [BSR_W-1:0] bsr_q;
    logic bsr_sout;

    genvar gi;
    generate
        for (gi = 0; gi < BSR_W; gi++) begin : g_pin_sync
            sjtap_sync u_pin_sync (
                .clk(tck),
                .rstn(trst_n),
                .d(bsr_pins_in[gi]),
                .q(pins_sync[gi])
            );
        end
    endgenerate

    sjtap_sreg #(.W(BSR_W)) u_bsr (
        .clk(tck),
        .rstn(trst_n),
        .cap_val(pins_sync),
        .cap(dr_cap && sel_bsr),
        .shift(dr_shift && sel_bsr),
        .sin(tdi_eff),
        .q(bsr_q),
        .sout(bsr_sout)
    );

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            bsr_drive <= '0;
        end else if ((state == TAP_UPDATE_DR) && sel_bsr) begin
            bsr_drive <= bsr_q;
        end
    end

    // =====================================================================
    // serial output
    logic dr_sout;

    assign dr_sout = sel_id ? id_sout : (sel_bsr ? bsr_sout : byp_sout);

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            tdo <= (state == TAP_SHIFT_IR) ? ir_sout : dr_sout;
            tdo_oe <= (state == TAP_SHIFT_IR) || (state == TAP_SHIFT_DR);
        end
    end

    // =====================================================================
    // instruction effect toward the ram
    // ir states keep the previous effect, the new one lands in idle or dr
    logic ext_lvl;
    logic hiz_lvl;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ext_lvl <= 1'h0;
            hiz_lvl <= 1'h0;
        end else if (state == TAP_TLR) begin
            ext_lvl <= 1'h0;
            hiz_lvl <= 1'h0;
        end else if (in_dr_side) begin
            ext_lvl <= (ir_active == IR_EXTEST);
            hiz_lvl <= (ir_active == IR_SAMPLEZ);
        end
    end

    sjtap_sync u_ext_sync (
        .clk(clk),
        .rstn(rstn),
        .d(ext_lvl),
        .q(ram_out_extest)
    );

    sjtap_sync u_hiz_sync (
        .clk(clk),
        .rstn(rstn),
        .d(hiz_lvl),
        .q(ram_out_hiz)
    );

    // =====================================================================
    // checks
    default clocking cb @(posedge tck);
    endclocking
    default disable iff (!trst_n);

    a_five_ones_reset: assert property ((tms_eff) [*5] |=> (state == TAP_TLR))
        else $error("five tms highs did not reach reset");

    a_ir_reset_value: assert property ((state == TAP_TLR) |-> (ir_active == IR_IDCODE))
        else $error("instruction not preset in reset state");

    a_ir_capture_pat: assert property ((state == TAP_CAPTURE_IR) |=> (ir_q[1:0] == IR_CAP_LO))
        else $error("capture pattern missing in instruction register");

    a_ir_held_stable: assert property (
        (state != TAP_UPDATE_IR) && (state != TAP_TLR) |-> (ir_active == $past(ir_active)))
        else $error("held instruction changed outside update");

    a_byp_capture_zero: assert property ((dr_cap && sel_byp) |=> (byp_q == BYP_CAP))
        else $error("bypass bit not cleared on capture");

    a_id_capture_val: assert property ((dr_cap && sel_id) |=> (id_q == ID_CODE))
        else $error("id register not loaded on capture");

    a_tdo_enable_win: assert property (
        tdo_oe == ((state == TAP_SHIFT_DR) || (state == TAP_SHIFT_IR)))
        else $error("tdo enable outside shift states");

    a_tdo_ir_bit: assert property ((state == TAP_SHIFT_IR) |-> (tdo == ir_q[0]))
        else $error("tdo does not show instruction bit");

    a_extest_path: assert property (
        ((ir_active == IR_EXTEST) && dr_shift) ##1 dr_shift |-> (tdo == bsr_q[0]))
        else $error("external test not routed through boundary register");

    a_ir_loads_only_sel: assert property (
        (state != TAP_SHIFT_IR) && (state != TAP_CAPTURE_IR) |=> (ir_q == $past(ir_q)))
        else $error("instruction register changed while unselected");

    a_byp_tdo_path: assert property ((dr_shift && sel_byp) |-> (tdo == byp_q))
        else $error("bypass bit not on serial output");

    a_id_tdo_path: assert property ((dr_shift && sel_id) |-> (tdo == id_q[0]))
        else $error("id bit 0 not on serial output");

    a_bsr_update_drv: assert property (
        ((state == TAP_UPDATE_DR) && sel_bsr) |=> (bsr_drive == bsr_q))
        else $error("boundary latch not loaded at update");

    a_hiz_follows_ir: assert property (
        (in_dr_side && (ir_active == IR_SAMPLEZ)) |=> hiz_lvl)
        else $error("sample-z effect missing in idle or dr state");

    c_enter_reset: cover property ((state != TAP_TLR) ##1 (state == TAP_TLR));
    c_new_instr: cover property ((state == TAP_UPDATE_IR) ##1 (ir_active == IR_BYPASS));
    c_id_shift: cover property ((dr_shift && sel_id) [*8]);
    c_bypass_shift: cover property (dr_shift && sel_byp);

endmodule : sjtap_port

// ==== sim/sjtap_ctl.sv ====
`timescale 1ns/1ps

// =====================================================================
// board-side scan controller model: tck runs only inside step
module sjtap_ctl (
    output logic tck,
    output logic tms_pin,
    output logic tms_float,
    output logic tdi_pin,
    output logic tdi_float,
    input wire logic tdo,
    input wire logic tdo_oe
);
    initial begin
        tck = 1'b0;
        tms_pin = 1'b1;
        tms_float = 1'b0;
        tdi_pin = 1'b0;
        tdi_float = 1'b0;
    end

    // one tck period; tdo is taken just before the rise, after the fall that launched it
    task automatic step(input logic ms, input logic di, output logic so, output logic oe);
        #1;
        tms_pin = ms;
        tdi_pin = di;
        #14;
        so = tdo;
        oe = tdo_oe;
        tck = 1'b1;
        #15;
        tck = 1'b0;
        // a released line must not keep showing the last level
        tdi_pin = ~di;
        tms_pin = ~ms;
    endtask : step
endmodule : sjtap_ctl

// ==== sim/sjtap_port_tb_top.sv ====
`timescale 1ns/1ps

// =====================================================================
// top-level bench
module sjtap_port_tb_top;
    import sjtap_pkg::*;
    localparam int BW = 8;
    localparam logic [ID_W-1:0] IDV = 32'h0000_0a5c; // arbitrary value

    logic clk, rstn, tck, tms_pin, tms_float, tdi_pin, tdi_float, tdo, tdo_oe;
    logic ram_out_extest, ram_out_hiz, o, oe;
    logic [BW-1:0] bsr_pins_in, bsr_drive;
    logic [IR_W-1:0] cur, c;
    logic [63:0] din, dout;
    int num_errors, checks_done, n, k;

    always #5 clk = ~clk;

    sjtap_port #(.BSR_W(BW), .ID_CODE(IDV)) dut (.clk(clk), .rstn(rstn), .tck(tck),
        .tms_pin(tms_pin), .tms_float(tms_float), .tdi_pin(tdi_pin), .tdi_float(tdi_float),
        .tdo(tdo), .tdo_oe(tdo_oe), .bsr_pins_in(bsr_pins_in), .bsr_drive(bsr_drive),
        .ram_out_extest(ram_out_extest), .ram_out_hiz(ram_out_hiz));

    sjtap_ctl ctl (.tck(tck), .tms_pin(tms_pin), .tms_float(tms_float), .tdi_pin(tdi_pin),
        .tdi_float(tdi_float), .tdo(tdo), .tdo_oe(tdo_oe));

    // =====================================================================
    // helpers
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [63:0] mask(input int l);
        return (64'h1 << l) - 64'h1;
    endfunction : mask

    function automatic logic [1:0] flg(input logic [2:0] x);
        return {x == IR_EXTEST, x == IR_SAMPLEZ};
    endfunction : flg

    function automatic int dr_len(input logic [2:0] x);
        if (x == IR_IDCODE) return ID_W;
        if (x == IR_EXTEST || x == IR_SAMPLEZ || x == IR_SAMPLE) return BW;
        return 1;
    endfunction : dr_len

    // capture value then the shifted-in bits, delayed by the register length
    function automatic logic [63:0] dr_exp(input logic [2:0] x, input logic [63:0] d,
                                           input logic [BW-1:0] pins);
        logic [63:0] cv;
        int l;
        l = dr_len(x);
        cv = (x == IR_IDCODE) ? 64'(IDV) : ((l == 1) ? 64'h0 : 64'(pins));
        return ((cv & mask(l)) | (d << l)) & mask(l + 4);
    endfunction : dr_exp

    // from idle: walk to shift, n bits lsb first, update, back to idle plus one idle rise
    task automatic scan(input bit ir, input int nb, input logic [63:0] di,
                        output logic [63:0] dq);
        int i;
        dq = 64'h0;
        ctl.step(1'b1, 1'b0, o, oe);
        if (ir) ctl.step(1'b1, 1'b0, o, oe);
        ctl.step(1'b0, 1'b0, o, oe);
        ctl.step(1'b0, 1'b0, o, oe);
        for (i = 0; i < nb; i++) begin
            ctl.step(i == nb - 1, di[i], o, oe);
            dq[i] = o;
            check(64'(oe), 64'h1);
        end
        repeat (4) @(posedge clk);
        check(64'({ram_out_extest, ram_out_hiz}), 64'(flg(cur)));
        ctl.step(1'b1, 1'b0, o, oe);
        ctl.step(1'b0, 1'b0, o, oe);
        ctl.step(1'b0, 1'b0, o, oe);
        check(64'(oe), 64'h0);
        repeat (4) @(posedge clk);
    endtask : scan

    initial begin
        #1000000;
        num_errors++;
        wrap_up();
    end

    // =====================================================================
    // main sequence
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        bsr_pins_in = '0;
        num_errors = 0;
        checks_done = 0;
        cur = IR_IDCODE;
        void'($urandom(75));
        #3;
        fork
            ctl.step(1'b1, 1'b0, o, oe);
            repeat (12) @(posedge clk);
        join
        #1 rstn = 1'b1;
        repeat (20) @(posedge clk);
        check(64'({ram_out_extest, ram_out_hiz}), 64'h0);
        repeat (3) ctl.step(1'b1, 1'b0, o, oe);
        ctl.step(1'b0, 1'b0, o, oe);
        din = {$urandom, $urandom};
        scan(0, ID_W + 4, din, dout);
        check(dout, dr_exp(IR_IDCODE, din, bsr_pins_in));
        // every code once, then random codes
        for (k = 0; k < 12; k++) begin
            c = (k < 8) ? IR_W'(k) : IR_W'($urandom);
            @(posedge clk);
            #1 bsr_pins_in = BW'($urandom);
            scan(1, IR_W, 64'(c), dout);
            check(dout, 64'(IR_CAP_LO));
            cur = c;
            check(64'({ram_out_extest, ram_out_hiz}), 64'(flg(c)));
            din = {$urandom, $urandom};
            n = dr_len(c) + 4;
            scan(0, n, din, dout);
            check(dout, dr_exp(c, din, bsr_pins_in));
            if (dr_len(c) == BW) begin
                check(64'(bsr_drive), (din >> 4) & mask(BW));
            end
        end
        // random walk, then five highs (driven, then floating) must reach reset
        for (k = 0; k < 2; k++) begin
            repeat (17) ctl.step(1'($urandom), 1'($urandom), o, oe);
            ctl.tms_float = (k == 1);
            repeat (5) ctl.step(k == 0, 1'b0, o, oe);
            ctl.tms_float = 1'b0;
            ctl.step(1'b0, 1'b0, o, oe);
            cur = IR_IDCODE;
            din = {$urandom, $urandom};
            scan(0, ID_W + 4, din, dout);
            check(dout, dr_exp(IR_IDCODE, din, bsr_pins_in));
        end
        // floating data input shifts ones through bypass
        scan(1, IR_W, 64'(IR_BYPASS), dout);
        cur = IR_BYPASS;
        ctl.tdi_float = 1'b1;
        scan(0, 5, 64'h0, dout);
        ctl.tdi_float = 1'b0;
        check(dout, 64'h1e);
        wrap_up();
    end
endmodule : sjtap_port_tb_top
